/* rtl/lcd_port_pkg.sv */
package lcd_port_pkg;
    // ****************************************
    // Register select in the write word
    // ****************************************
    localparam int REG_ID_LSB = 28;
    localparam logic [3:0] REG_ID_EXT = 4'hc;
    localparam logic [3:0] REG_ID_CON = 4'he;
    localparam logic [3:0] REG_ID_VMUX = 4'hf;
    localparam int EXT_W = 20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int EXT_PSEL_LSB = 0;
    localparam int EXT_CLKEN_BIT = 2;
    localparam int EXT_DC_LSB = 4;
    localparam int EXT_PED_LSB = 8;
    localparam int EXT_DACEN_BIT = 12;
    localparam int EXT_LCD_BIT = 13;
    localparam int EXT_HIRES_BIT = 14;
    localparam int EXT_HPOL_BIT = 16;
    localparam int EXT_VPOL_BIT = 17;
    localparam int EXT_HCOMP_BIT = 18;
    localparam int EXT_VCOMP_BIT = 19;
    localparam int CON_DUP_BIT = 13;
    localparam int VMUX_ALT_BIT = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [EXT_W-1:0] EXT_RESET = 20'h00000;
    localparam logic CON_DUP_RESET = 1'b0;
    localparam logic VMUX_ALT_RESET = 1'b0;

    // ****************************************
    // Port selector codes
    // ****************************************
    localparam logic [1:0] PSEL_RED = 2'h0;
    localparam logic [1:0] PSEL_GREEN = 2'h1;
    localparam logic [1:0] PSEL_BLUE = 2'h2;
    localparam logic [1:0] PSEL_EXT = 2'h3;

    // 4x4 ordered dither thresholds, nibble index {raster[1:0], column[1:0]}
    localparam logic [63:0] DITHER = 64'h5d7f91b36e4ca280;
    localparam int VCOUNT_W = 10;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b01,
        XFER_BUSY = 2'b10
    } xfer_state_e;
endpackage

/* rtl/lcd_port_out.sv */
`timescale 1ns/1ns
module lcd_port_out (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic reg_busy_o,
    output logic dac_enable_o,
    output logic fetch_pair_o,
    input wire logic pix2x_clk_i,
    input wire logic [7:0] red_lut_i,
    input wire logic [7:0] green_lut_i,
    input wire logic [7:0] blue_lut_i,
    input wire logic [3:0] ext_lut_i,
    input wire logic [7:0] cursor_i,
    input wire logic hdisp_i,
    input wire logic border_i,
    input wire logic hsync_i,
    input wire logic vsync_i,
    input wire logic genlock_sync_i,
    output logic [7:0] ext_data_port_o,
    output logic ext_port_clock_o,
    output logic hsync_o,
    output logic vsync_o,
    output logic [2:0] pedestal_on_o,
    output logic [lcd_port_pkg::VCOUNT_W-1:0] vcount_o
);
    // ****************************************
    // Register side, write-only control words
    // ****************************************
    logic [lcd_port_pkg::EXT_W-1:0] ext_control_reg;
    logic dup_reg;
    logic alt_reg;
    logic req_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_reg;
    lcd_port_pkg::xfer_state_e state_reg;
    logic [3:0] wr_id;
    logic wr_take;

    assign wr_id = reg_wdata_i[lcd_port_pkg::REG_ID_LSB +: 4];
    // Writes during a transfer are dropped so the pixel side sees stable words
    assign wr_take = reg_wr_i && (state_reg == lcd_port_pkg::XFER_IDLE) &&
                     (wr_id == lcd_port_pkg::REG_ID_EXT || wr_id == lcd_port_pkg::REG_ID_CON ||
                      wr_id == lcd_port_pkg::REG_ID_VMUX);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ext_control_reg <= lcd_port_pkg::EXT_RESET;
            dup_reg <= lcd_port_pkg::CON_DUP_RESET;
            alt_reg <= lcd_port_pkg::VMUX_ALT_RESET;
        end else if (wr_take) begin
            if (wr_id == lcd_port_pkg::REG_ID_EXT) begin
                ext_control_reg <= reg_wdata_i[lcd_port_pkg::EXT_W-1:0];
            end
            if (wr_id == lcd_port_pkg::REG_ID_CON) begin
                dup_reg <= reg_wdata_i[lcd_port_pkg::CON_DUP_BIT];
            end
            if (wr_id == lcd_port_pkg::REG_ID_VMUX) begin
                alt_reg <= reg_wdata_i[lcd_port_pkg::VMUX_ALT_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= lcd_port_pkg::XFER_IDLE;
            req_reg <= 1'b0;
        end else begin
            case (state_reg)
                lcd_port_pkg::XFER_IDLE: begin
                    if (wr_take) begin
                        req_reg <= ~req_reg;
                        state_reg <= lcd_port_pkg::XFER_BUSY;
                    end
                end
                lcd_port_pkg::XFER_BUSY: begin
                    if (ack_s2_reg == req_reg) begin
                        state_reg <= lcd_port_pkg::XFER_IDLE;
                    end
                end
                default: begin
                    state_reg <= lcd_port_pkg::XFER_IDLE;
                end
            endcase
        end
    end

    assign reg_busy_o = state_reg[1];
    assign dac_enable_o = ext_control_reg[lcd_port_pkg::EXT_DACEN_BIT];
    // Fetch asks for an upper/lower quadword pair; memory keeps that order
    assign fetch_pair_o = dup_reg;

    // ****************************************
    // Pixel side: reset and control crossing
    // ****************************************
    logic prst_s1_reg;
    logic prst_n;
    logic req_s1_reg;
    logic req_s2_reg;
    logic [lcd_port_pkg::EXT_W-1:0] ext_p;
    logic dup_p;
    logic alt_p;

    always_ff @(posedge pix2x_clk_i) begin
        prst_s1_reg <= resetn_i;
        prst_n <= prst_s1_reg;
    end

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            ack_reg <= 1'b0;
            ext_p <= lcd_port_pkg::EXT_RESET;
            dup_p <= lcd_port_pkg::CON_DUP_RESET;
            alt_p <= lcd_port_pkg::VMUX_ALT_RESET;
        end else begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            ack_reg <= req_s2_reg;
            if (req_s2_reg != ack_reg) begin
                ext_p <= ext_control_reg;
                dup_p <= dup_reg;
                alt_p <= alt_reg;
            end
        end
    end

    logic [1:0] psel;
    logic clken_p;
    logic lcd_p;
    logic lcd_mode;
    assign psel = ext_p[lcd_port_pkg::EXT_PSEL_LSB +: 2];
    assign clken_p = ext_p[lcd_port_pkg::EXT_CLKEN_BIT];
    assign lcd_p = ext_p[lcd_port_pkg::EXT_LCD_BIT];
    assign lcd_mode = lcd_p && (psel == lcd_port_pkg::PSEL_GREEN);

    // ****************************************
    // Pixel phase: two link edges per pixel
    // ****************************************
    logic ph_reg;
    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            ph_reg <= 1'b0;
        end else begin
            ph_reg <= ~ph_reg;
        end
    end

    // ****************************************
    // Grayscaler
    // ****************************************
    logic [1:0] hcol_reg;
    logic [2:0] up_sh_reg;
    logic [2:0] lo_sh_reg;
    logic [5:0] didx;
    logic [3:0] thr;
    logic gray_up;
    logic gray_lo;
    logic nib_emit;

    assign didx = {vcount_o[1:0], hcol_reg, 2'h0};
    assign thr = lcd_port_pkg::DITHER[didx +: 4];
    // Both streams dithered in the same pixel for duplex
    assign gray_up = green_lut_i[3:0] > thr;
    assign gray_lo = ext_lut_i > thr;
    assign nib_emit = ph_reg && lcd_mode && hdisp_i && (hcol_reg == 2'h3);

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            hcol_reg <= 2'h0;
            up_sh_reg <= 3'h0;
            lo_sh_reg <= 3'h0;
        end else if (ph_reg) begin
            if (hdisp_i) begin
                hcol_reg <= hcol_reg + 2'h1;
                up_sh_reg <= {up_sh_reg[1:0], gray_up};
                lo_sh_reg <= {lo_sh_reg[1:0], gray_lo};
            end else begin
                hcol_reg <= 2'h0;
            end
        end
    end

    // ****************************************
    // High-res cursor merge and delays
    // ****************************************
    logic [7:0] hr_merge;
    logic [7:0] hr_d_reg;
    logic [3:0] ext_d_reg;

    for (genvar i = 0; i < 4; i++) begin : g_pair
        assign hr_merge[2*i +: 2] = cursor_i[2*i] ? {2{cursor_i[2*i+1]}} : blue_lut_i[2*i +: 2];
    end

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            hr_d_reg <= 8'h00;
            ext_d_reg <= 4'h0;
        end else if (ph_reg) begin
            hr_d_reg <= hr_merge;
            ext_d_reg <= ext_lut_i;
        end
    end

    // ****************************************
    // Data port
    // ****************************************
    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            ext_data_port_o <= 8'h00;
        end else if (lcd_mode) begin
            if (nib_emit) begin
                // Single panel keeps the low nibble quiet
                ext_data_port_o <= {up_sh_reg, gray_up, dup_p ? {lo_sh_reg, gray_lo} : 4'h0};
            end
        end else if (psel == lcd_port_pkg::PSEL_RED && alt_p) begin
            ext_data_port_o <= ph_reg ? red_lut_i : green_lut_i;
        end else if (ph_reg) begin
            case (psel)
                lcd_port_pkg::PSEL_RED: ext_data_port_o <= red_lut_i;
                lcd_port_pkg::PSEL_GREEN: ext_data_port_o <= green_lut_i;
                lcd_port_pkg::PSEL_BLUE: begin
                    ext_data_port_o <= ext_p[lcd_port_pkg::EXT_HIRES_BIT] ? hr_d_reg : blue_lut_i;
                end
                lcd_port_pkg::PSEL_EXT: begin
                    ext_data_port_o <= {ext_p[lcd_port_pkg::EXT_DC_LSB +: 4],
                                        ext_p[lcd_port_pkg::EXT_DACEN_BIT] ? ext_d_reg : ext_lut_i};
                end
                default: ext_data_port_o <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Port clock
    // ****************************************
    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            ext_port_clock_o <= 1'b0;
        end else if (!clken_p) begin
            ext_port_clock_o <= 1'b0;
        end else if (lcd_p) begin
            // High over pixels 2 and 3 of each group, so the nibble is settled at the rise
            if (ph_reg) begin
                ext_port_clock_o <= hdisp_i && (hcol_reg == 2'h1 || hcol_reg == 2'h2);
            end
        end else begin
            ext_port_clock_o <= ~ph_reg;
        end
    end

    // ****************************************
    // Syncs, genlock and vertical counter
    // ****************************************
    logic gl_s1_reg;
    logic gl_s2_reg;
    logic gl_s3_reg;
    logic hs_prev_reg;
    logic vs_prev_reg;
    logic gl_edge;
    logic hs_comp;
    logic vs_comp;

    assign gl_edge = gl_s2_reg && !gl_s3_reg;
    assign hs_comp = ext_p[lcd_port_pkg::EXT_HCOMP_BIT] ? (hsync_i || vsync_i) : hsync_i;
    assign vs_comp = ext_p[lcd_port_pkg::EXT_VCOMP_BIT] ? (hsync_i ^ vsync_i) : vsync_i;

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            gl_s1_reg <= 1'b0;
            gl_s2_reg <= 1'b0;
            gl_s3_reg <= 1'b0;
            hs_prev_reg <= 1'b0;
            vs_prev_reg <= 1'b0;
        end else begin
            gl_s1_reg <= genlock_sync_i;
            gl_s2_reg <= gl_s1_reg;
            gl_s3_reg <= gl_s2_reg;
            hs_prev_reg <= hsync_i;
            vs_prev_reg <= vsync_i;
        end
    end

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            vcount_o <= '0;
        end else if (gl_edge || (vsync_i && !vs_prev_reg)) begin
            vcount_o <= '0;
        end else if (hsync_i && !hs_prev_reg) begin
            vcount_o <= vcount_o + 10'h001;
        end
    end

    always_ff @(posedge pix2x_clk_i) begin
        if (!prst_n) begin
            hsync_o <= 1'b0;
            vsync_o <= 1'b0;
            pedestal_on_o <= 3'h0;
        end else begin
            hsync_o <= hs_comp ^ ext_p[lcd_port_pkg::EXT_HPOL_BIT];
            vsync_o <= vs_comp ^ ext_p[lcd_port_pkg::EXT_VPOL_BIT];
            pedestal_on_o <= ext_p[lcd_port_pkg::EXT_PED_LSB +: 3] & {3{border_i}};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_clk_off: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        !clken_p |=> !ext_port_clock_o) else $error("port clock not held low");
    chk_pix_clock: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (clken_p && !lcd_p) |=> ext_port_clock_o == !$past(ph_reg)) else $error("port clock not pixel clock");
    chk_single_low: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (nib_emit && !dup_p) |=> ext_data_port_o[3:0] == 4'h0) else $error("low nibble not quiet");
    chk_alt_red: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (alt_p && !lcd_mode && psel == lcd_port_pkg::PSEL_RED && ph_reg)
        |=> ext_data_port_o == $past(red_lut_i) ##1 ext_data_port_o == $past(green_lut_i))
        else $error("alternate colour order wrong");
    chk_green_sel: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (!lcd_p && psel == lcd_port_pkg::PSEL_GREEN && ph_reg) |=> ext_data_port_o == $past(green_lut_i))
        else $error("green table not on port");
    chk_dc_nibble: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (psel == lcd_port_pkg::PSEL_EXT && ph_reg) |=> ext_data_port_o[7:4] == $past(ext_p[7:4]))
        else $error("control nibble wrong");
    chk_ext_delay: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        (psel == lcd_port_pkg::PSEL_EXT && ext_p[lcd_port_pkg::EXT_DACEN_BIT] && ph_reg) ##2
        (psel == lcd_port_pkg::PSEL_EXT && ext_p[lcd_port_pkg::EXT_DACEN_BIT])
        |=> ext_data_port_o[3:0] == $past(ext_lut_i, 3)) else $error("external nibble not delayed");
    chk_ped_border: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        !border_i |=> pedestal_on_o == 3'h0) else $error("pedestal outside border");
    chk_genlock_reset: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        gl_edge |=> vcount_o == '0) else $error("genlock did not reset raster");
    chk_comp_hsync: assert property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        ext_p[lcd_port_pkg::EXT_HCOMP_BIT] |=>
        hsync_o == ($past(hsync_i || vsync_i) ^ $past(ext_p[lcd_port_pkg::EXT_HPOL_BIT])))
        else $error("composite sync wrong");
    cov_duplex: cover property (@(posedge pix2x_clk_i) disable iff (!prst_n) nib_emit && dup_p);
    cov_genlock: cover property (@(posedge pix2x_clk_i) disable iff (!prst_n) gl_edge);
    cov_hires: cover property (@(posedge pix2x_clk_i) disable iff (!prst_n)
        psel == lcd_port_pkg::PSEL_BLUE && ext_p[lcd_port_pkg::EXT_HIRES_BIT] && ph_reg);
    cov_write: cover property (@(posedge clk_i) disable iff (!resetn_i) wr_take ##[1:20] !reg_busy_o);
endmodule

/* tb/lcd_panel_model.sv */
`timescale 1ns/1ns
// ****************************************
// Latching logic at the far side of the port
// ****************************************
module lcd_panel_model (
    input wire logic [7:0] ext_data_port_i,
    input wire logic ext_port_clock_i,
    output logic [7:0] latched_o
);
    // Data taken on the rising port clock, as an external latch would
    always_ff @(posedge ext_port_clock_i) begin
        latched_o <= ext_data_port_i;
    end
endmodule

/* tb/lcd_external_port_output_tb.sv */
`timescale 1ns/1ns
module lcd_external_port_output_tb;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk_i = 1'b0;
    logic pix2x_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic [7:0] red_lut_i = 8'h00;
    logic [7:0] green_lut_i = 8'h00;
    logic [7:0] blue_lut_i = 8'h00;
    logic [3:0] ext_lut_i = 4'h0;
    logic [7:0] cursor_i = 8'h00;
    logic hdisp_i = 1'b0;
    logic border_i = 1'b0;
    logic hsync_i = 1'b0;
    logic vsync_i = 1'b0;
    logic genlock_sync_i = 1'b0;
    logic reg_busy_o, dac_enable_o, fetch_pair_o, ext_port_clock_o, hsync_o, vsync_o;
    logic [7:0] ext_data_port_o;
    logic [7:0] latched;
    logic [2:0] pedestal_on_o;
    logic [lcd_port_pkg::VCOUNT_W-1:0] vcount_o;
    int fails = 0;
    int num_checks = 0;
    int seed = 32'h243c;
    int cnt = 0;
    logic [15:0] exp_q[$];
    int sel_q[$];
    event smp;

    always #20 clk_i = ~clk_i;
    // Odd start offset keeps the link clock out of phase with clk_i
    initial begin
        #7;
        forever #24 pix2x_clk_i = ~pix2x_clk_i;
    end

    lcd_port_out lcd_port_out_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_busy_o(reg_busy_o), .dac_enable_o(dac_enable_o), .fetch_pair_o(fetch_pair_o), .pix2x_clk_i(pix2x_clk_i),
        .red_lut_i(red_lut_i), .green_lut_i(green_lut_i), .blue_lut_i(blue_lut_i), .ext_lut_i(ext_lut_i),
        .cursor_i(cursor_i), .hdisp_i(hdisp_i), .border_i(border_i), .hsync_i(hsync_i), .vsync_i(vsync_i),
        .genlock_sync_i(genlock_sync_i), .ext_data_port_o(ext_data_port_o), .ext_port_clock_o(ext_port_clock_o),
        .hsync_o(hsync_o), .vsync_o(vsync_o), .pedestal_on_o(pedestal_on_o), .vcount_o(vcount_o));

    lcd_panel_model lcd_panel_model_i (.ext_data_port_i(ext_data_port_o), .ext_port_clock_i(ext_port_clock_o),
        .latched_o(latched));

    // ****************************************
    // Scoreboard
    // ****************************************
    task test_done;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task note(input int sel, input logic [15:0] e);
        sel_q.push_back(sel);
        exp_q.push_back(e);
        -> smp;
        #1;
    endtask

    function logic [15:0] obs(input int sel);
        case (sel)
            0: obs = {8'h00, ext_data_port_o};
            1: obs = {15'h0000, ext_port_clock_o};
            2: obs = {14'h0000, vsync_o, hsync_o};
            3: obs = {13'h0000, pedestal_on_o};
            4: obs = {6'h00, vcount_o};
            5: obs = {14'h0000, fetch_pair_o, dac_enable_o};
            6: obs = {8'h00, latched};
            default: obs = cnt[15:0];
        endcase
    endfunction

    // Row 0 of the dither table, first pixel in the top bit
    function logic [3:0] dith(input logic [3:0] v);
        for (int c = 0; c < 4; c++) begin
            dith[3-c] = v > lcd_port_pkg::DITHER[4*c +: 4];
        end
    endfunction

    always @(smp) begin
        logic [15:0] e;
        int s;
        s = sel_q.pop_front();
        e = exp_q.pop_front();
        num_checks++;
        if (obs(s) !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, obs(s));
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    task lnk(input int n);
        repeat (n) @(negedge pix2x_clk_i);
    endtask

    // Waits out the crossing so the link side holds the new value
    task wr(input logic [3:0] id, input logic [27:0] v);
        int n;
        n = 0;
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_wdata_i = {id, v};
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        while (reg_busy_o !== 1'b0 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 100)
            fails++;
        lnk(4);
    endtask

    task ext(input logic [19:0] v);
        wr(lcd_port_pkg::REG_ID_EXT, {8'h00, v});
    endtask

    task rises(input int n);
        logic p;
        cnt = 0;
        p = ext_port_clock_o;
        repeat (n) begin
            @(negedge pix2x_clk_i);
            if (ext_port_clock_o === 1'b1 && p === 1'b0)
                cnt++;
            p = ext_port_clock_o;
        end
    endtask

    task pulse_h;
        hsync_i = 1'b1;
        lnk(2);
        hsync_i = 1'b0;
        lnk(2);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [19:0] sc[4];
        logic [1:0] si[4];
        logic [1:0] so[4];
        logic [7:0] ev[3];
        logic [7:0] hr;
        sc = '{20'h00000, 20'h40000, 20'hc0000, 20'h30000};
        si = '{2'b01, 2'b10, 2'b11, 2'b01};
        so = '{2'b01, 2'b11, 2'b01, 2'b10};
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        red_lut_i = $random(seed);
        green_lut_i = $random(seed);
        blue_lut_i = $random(seed);
        ext_lut_i = $random(seed);
        cursor_i = $random(seed);
        ev = '{red_lut_i, green_lut_i, blue_lut_i};
        ext(20'h01000);
        wr(lcd_port_pkg::REG_ID_CON, 28'h0002000);
        note(5, 16'h0003);
        wr(lcd_port_pkg::REG_ID_CON, 28'h0000000);
        ext(20'h00000);
        note(5, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            ext(20'h00004 | s);
            note(0, {8'h00, ev[s]});
        end
        ext(20'h04006);
        for (int i = 0; i < 4; i++) begin
            hr[2*i +: 2] = cursor_i[2*i] ? {2{cursor_i[2*i+1]}} : blue_lut_i[2*i +: 2];
        end
        note(0, {8'h00, hr});
        ext(20'h00005);
        note(6, {8'h00, green_lut_i});
        rises(8);
        note(7, 16'h0004);
        ext(20'h00001);
        rises(16);
        note(7, 16'h0000);
        ext(20'h000a7);
        note(0, {8'h00, 4'ha, ext_lut_i});
        ext(20'h010a7);
        ext_lut_i = ~ext_lut_i;
        lnk(2);
        note(0, {8'h00, 4'ha, ~ext_lut_i});
        lnk(2);
        note(0, {8'h00, 4'ha, ext_lut_i});
        wr(lcd_port_pkg::REG_ID_VMUX, 28'h0000002);
        ext(20'h00004);
        repeat (6) begin
            lnk(1);
            note(0, {8'h00, (ext_port_clock_o === 1'b1) ? green_lut_i : red_lut_i});
        end
        wr(lcd_port_pkg::REG_ID_VMUX, 28'h0000000);
        green_lut_i = {green_lut_i[7:4], 4'h5};
        ext_lut_i = 4'hf;
        hdisp_i = 1'b1;
        ext(20'h02005);
        lnk(16);
        note(0, {8'h00, dith(4'h5), 4'h0});
        wr(lcd_port_pkg::REG_ID_CON, 28'h0002000);
        lnk(16);
        note(0, {8'h00, dith(4'h5), dith(4'hf)});
        wr(lcd_port_pkg::REG_ID_CON, 28'h0000000);
        rises(16);
        note(7, 16'h0002);
        hdisp_i = 1'b0;
        lnk(8);
        rises(16);
        note(7, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            ext(sc[k]);
            hsync_i = si[k][0];
            vsync_i = si[k][1];
            lnk(2);
            note(2, {14'h0000, so[k]});
        end
        hsync_i = 1'b0;
        vsync_i = 1'b0;
        ext(20'h00500);
        border_i = 1'b1;
        lnk(2);
        note(3, 16'h0005);
        border_i = 1'b0;
        lnk(2);
        note(3, 16'h0000);
        vsync_i = 1'b1;
        lnk(2);
        vsync_i = 1'b0;
        lnk(2);
        repeat (3) pulse_h;
        note(4, 16'h0003);
        genlock_sync_i = 1'b1;
        lnk(8);
        note(4, 16'h0000);
        genlock_sync_i = 1'b0;
        test_done;
    end

    // Whole sequence needs well under a quarter of this span
    initial begin
        #400000;
        fails++;
        test_done;
    end
endmodule
